// ==== core/lcr_pkg.sv ====
// Constants, modes and types shared by the logic cell files
// How it works
// [R1] Cell offers normal, arithmetic, up/down counter and clearable counter modes.
// [R2] Six logic inputs plus clock, clear and preset feed the cell.
// [R3] Register has a synchronous enable, optionally taken from the first data input.
// [R4] Clearable counter uses cascade-in as synchronous clear instead of direction.
// [R5] Clearable counter splits the table into two three-input halves: bit and carry.
// [R6] Load mux picks count or load data, then is ANDed with the inverted clear.
// [R7] Bus emulation: contention resolves low, no driver resolves high.
// [R8] Clear and preset come from third input and the two cluster lines.
// [R9] Asynchronous load puts the third input into the register at once.
// [R10] Clear and preset are active low; unused ones stay high.
// [R11] Six asynchronous control modes are selectable.
// [R12] Active clear beats preset or load when both are asserted.
// [R13] Register captures on enabled rising edges without async control, else holds.
package lcr_pkg;

  // Operating modes of the cell
  typedef enum logic [1:0] {
    LCR_OP_NORMAL = 2'h0,
    LCR_OP_ARITH  = 2'h1,
    LCR_OP_UPDN   = 2'h2,
    LCR_OP_CLRCNT = 2'h3
  } lcr_op_mode_t;

  // Asynchronous control modes
  typedef enum logic [2:0] {
    LCR_AS_CLR     = 3'h0,
    LCR_AS_PRE     = 3'h1,
    LCR_AS_CLR_PRE = 3'h2,
    LCR_AS_LD_CLR  = 3'h3,
    LCR_AS_LD_PRE  = 3'h4,
    LCR_AS_LD_ONLY = 3'h5
  } lcr_async_mode_t;

  // Table and bus sizes
  localparam int unsigned LCR_LUT_BITS = 16;
  localparam int unsigned LCR_TBUS_N   = 4;

  // Table half selects: low half data, high half carry
  localparam logic LCR_HALF_DATA  = 1'h0;
  localparam logic LCR_HALF_CARRY = 1'h1;

  // Values after reset and bus resolution levels
  localparam logic LCR_REG_RST    = 1'h0;
  localparam logic LCR_TBUS_RST   = 1'h1;
  localparam logic LCR_TBUS_FLOAT = 1'h1;
  localparam logic LCR_TBUS_FIGHT = 1'h0;

  // Cluster line select for the clear source
  localparam logic LCR_SEL_LINE_A = 1'h0;

endpackage

// ==== core/lcr_tbus_if.sv ====
// Carrier between the cell and its bus resolver
`timescale 1ns/100ps
`default_nettype none
interface lcr_tbus_if;
  import lcr_pkg::*;
  logic [LCR_TBUS_N-1:0] drv_data;
  logic [LCR_TBUS_N-1:0] drv_en;
  logic                  resolved;
  logic                  clk;

  // Cell drives the sources and the check clock, resolver returns the level
  modport src (output drv_data, output drv_en, input resolved);
  modport res (input drv_data, input drv_en, input clk, output resolved);
endinterface
`default_nettype wire

// ==== core/lcr_tbus_res.sv ====
// Multiplexer emulation of an internal tri-state bus
`timescale 1ns/100ps
`default_nettype none
module lcr_tbus_res (
  // Bus sources and result
  lcr_tbus_if.res tb
);
  import lcr_pkg::*;

  logic [LCR_TBUS_N-1:0] hit;
  logic [2:0]            n_en;

  // Per-driver selected data
  genvar gi;
  generate
    for (gi = 0; gi < LCR_TBUS_N; gi++)
    begin : g_drv
      assign hit[gi] = tb.drv_en[gi] & tb.drv_data[gi];
    end
  endgenerate

  // Count enables, then resolve
  always_comb
  begin
    n_en = 3'h0;
    for (int i = 0; i < LCR_TBUS_N; i++)
      n_en = n_en + {2'h0, tb.drv_en[i]};
    if (n_en == 3'h0)
      tb.resolved = LCR_TBUS_FLOAT; // R7
    else if (n_en == 3'h1)
      tb.resolved = |hit;
    else
      tb.resolved = LCR_TBUS_FIGHT; // R7
  end

  // Resolution checks
  a_bus_float: assert property (@(posedge tb.clk) // R7
    (tb.drv_en == '0) |-> tb.resolved)
    else $error("floating bus not high");
  a_bus_fight: assert property (@(posedge tb.clk) // R7
    !$onehot0(tb.drv_en) |-> !tb.resolved)
    else $error("contending bus not low");

endmodule
`default_nettype wire

// ==== core/lcr_cell.sv ====
// One programmable logic cell with register control and bus emulation
`timescale 1ns/100ps
`default_nettype none
module lcr_cell (
  // Clock and reset
  input  wire logic                    sys_clk_in,
  input  wire logic                    nrst_in,
  // Configuration
  input  wire lcr_pkg::lcr_op_mode_t   op_mode_in,
  input  wire lcr_pkg::lcr_async_mode_t async_mode_in,
  input  wire logic                    clr_src_sel_in,
  input  wire logic                    en_sel_in,
  input  wire logic [15:0]             lut_mask_in,
  // Data inputs
  input  wire logic                    cell_input_first_in,
  input  wire logic                    cell_input_second_in,
  input  wire logic                    cell_input_third_in,
  input  wire logic                    cell_input_fourth_in,
  // Chain inputs from the preceding cell
  input  wire logic                    carry_chain_in,
  input  wire logic                    cascade_chain_in,
  // Cluster control lines
  input  wire logic                    cluster_ctrl_a_in,
  input  wire logic                    cluster_ctrl_b_in,
  // Emulated bus sources
  input  wire logic [3:0]              tbus_data_in,
  input  wire logic [3:0]              tbus_en_in,
  // Outputs
  output logic                         reg_out,
  output logic                         carry_out,
  output logic                         cascade_out,
  output logic                         tbus_out
);
  import lcr_pkg::*;

  // Short names for the data inputs
  logic d1;
  logic d2;
  logic d3;
  logic d4;
  logic cin;
  logic casc_in;

  // Datapath
  logic       reg_q;
  logic       next_q;
  logic       cell_en;
  logic       lut4_out;
  logic [2:0] idx3;
  logic       lut_data;
  logic       lut_carry;
  logic       cnt_bit;
  logic       cnt_carry;
  logic       load_mux;
  logic       cell_data;

  // Asynchronous control
  logic clr_line;
  logic other_line;
  logic clr_req;
  logic pre_req;
  logic ld_req;
  logic async_clr_n;
  logic async_pre_n;
  logic async_idle;

  // Bus emulation
  logic        tbus_q;
  logic        next_tbus;
  lcr_tbus_if  tb_if ();

  assign d1      = cell_input_first_in; // R2
  assign d2      = cell_input_second_in;
  assign d3      = cell_input_third_in;
  assign d4      = cell_input_fourth_in;
  assign cin     = carry_chain_in; // R2
  assign casc_in = cascade_chain_in;

  // Enable: first data input when selected, else always on
  assign cell_en = en_sel_in ? d1 : 1'h1; // R3

  // Four-input table lookup used by normal mode
  assign lut4_out = lut_mask_in[{d4, d3, d2, d1}];

  // Three-input index per mode
  always_comb
  begin
    idx3 = {cin, d2, d1};
    if (op_mode_in == LCR_OP_CLRCNT)
      idx3 = {cin, d2, reg_q}; // R5
  end

  // Two three-input halves: data and fast carry
  assign lut_data  = lut_mask_in[{LCR_HALF_DATA, idx3}]; // R5
  assign lut_carry = lut_mask_in[{LCR_HALF_CARRY, idx3}]; // R5

  // Up/down counting bit; cascade-in gives the direction
  always_comb
  begin
    cnt_bit = reg_q ^ cin;
    if (casc_in)
      cnt_carry = reg_q & cin;
    else
      cnt_carry = ~reg_q & cin;
  end

  // Mode steering of the cell inputs
  always_comb
  begin
    load_mux    = 1'h0;
    cell_data   = 1'h0;
    carry_out   = 1'h0;
    cascade_out = 1'h0;
    case (op_mode_in) // R1
      LCR_OP_NORMAL:
      begin
        cell_data   = lut4_out & casc_in;
        cascade_out = cell_data;
      end
      LCR_OP_ARITH:
      begin
        cell_data   = lut_data & casc_in;
        cascade_out = cell_data;
        carry_out   = lut_carry;
      end
      LCR_OP_UPDN:
      begin
        load_mux  = d4 ? d3 : cnt_bit;
        cell_data = load_mux;
        carry_out = cnt_carry;
      end
      LCR_OP_CLRCNT:
      begin
        load_mux  = d4 ? d3 : lut_data; // R6
        cell_data = load_mux & ~casc_in; // R4 R6
        carry_out = lut_carry; // R5
      end
      default:
      begin
        cell_data = 1'h0;
      end
    endcase
  end

  // Next register value under the enable
  always_comb
  begin
    next_q = reg_q;
    if (cell_en)
      next_q = cell_data; // R3 R13
  end

  // Source lines for the asynchronous controls
  always_comb
  begin
    clr_line   = cluster_ctrl_a_in;
    other_line = cluster_ctrl_b_in;
    if (clr_src_sel_in != LCR_SEL_LINE_A)
    begin
      clr_line   = cluster_ctrl_b_in; // R8
      other_line = cluster_ctrl_a_in;
    end
  end

  // Asynchronous mode decode
  always_comb
  begin
    clr_req = 1'h0;
    pre_req = 1'h0;
    ld_req  = 1'h0;
    case (async_mode_in) // R11
      LCR_AS_CLR:
      begin
        clr_req = clr_line; // R8
      end
      LCR_AS_PRE:
      begin
        pre_req = clr_line;
      end
      LCR_AS_CLR_PRE:
      begin
        clr_req = clr_line; // R8
        pre_req = other_line;
      end
      LCR_AS_LD_CLR:
      begin
        ld_req  = cluster_ctrl_a_in; // R9
        clr_req = cluster_ctrl_b_in;
      end
      LCR_AS_LD_PRE:
      begin
        ld_req  = cluster_ctrl_a_in; // R9
        pre_req = cluster_ctrl_b_in;
      end
      LCR_AS_LD_ONLY:
      begin
        ld_req = cluster_ctrl_a_in; // R9
      end
      default:
      begin
        ld_req = 1'h0;
      end
    endcase
  end

  // Active-low clear and preset; load steers them from the third input
  // Preset is masked while clear or reset is low, so their release gives a fresh preset edge
  assign async_clr_n = ~(clr_req | (ld_req & ~d3)); // R8 R9 R10
  assign async_pre_n = ~((pre_req | (ld_req & d3)) & async_clr_n & nrst_in); // R10 R12
  assign async_idle  = async_clr_n & async_pre_n;

  // Cell register with asynchronous clear and preset
  always_ff @(posedge sys_clk_in or negedge nrst_in
              or negedge async_clr_n or negedge async_pre_n)
  begin
    if (!nrst_in)
      reg_q <= LCR_REG_RST;
    else if (!async_clr_n)
      reg_q <= 1'h0; // R12
    else if (!async_pre_n)
      reg_q <= 1'h1;
    else
      reg_q <= next_q; // R13
  end

  assign reg_out = reg_q;

  // Bus sources and resolver
  assign tb_if.drv_data = tbus_data_in;
  assign tb_if.drv_en   = tbus_en_in;
  assign tb_if.clk      = sys_clk_in;

  lcr_tbus_res u_tbus (
    .tb (tb_if.res)
  );

  // Registered bus level
  always_comb
  begin
    next_tbus = tb_if.resolved; // R7
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      tbus_q <= LCR_TBUS_RST;
    else
      tbus_q <= next_tbus;
  end

  assign tbus_out = tbus_q;

  // Checks on the register and its controls
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_idle_hold;
    !cell_en && async_idle ##1 async_idle;
  endsequence

  sequence s_idle_cap;
    cell_en && async_idle ##1 async_idle;
  endsequence

  sequence s_sync_clr;
    op_mode_in == LCR_OP_CLRCNT && casc_in && cell_en && async_idle ##1 async_idle;
  endsequence

  a_enable_hold: assert property (s_idle_hold |-> reg_q == $past(reg_q)) // R3
    else $error("register changed while disabled");

  a_edge_capture: assert property (s_idle_cap |-> reg_q == $past(next_q)) // R13
    else $error("register missed enabled capture");

  a_sync_clear: assert property (s_sync_clr |-> !reg_q) // R4
    else $error("synchronous clear did not zero register");

  a_carry_half: assert property ( // R5
    op_mode_in == LCR_OP_CLRCNT |-> carry_out == lut_mask_in[{LCR_HALF_CARRY, cin, d2, reg_q}])
    else $error("carry not from upper table half");

  a_clear_wins: assert property (clr_req |-> !async_clr_n && async_pre_n && !reg_q) // R12
    else $error("clear lost to preset or load");

  a_preset_sets: assert property (async_clr_n && !async_pre_n |-> reg_q) // R10
    else $error("preset did not set register");

  a_async_load: assert property (ld_req && !clr_req |-> reg_q == d3) // R9
    else $error("asynchronous load value wrong");

  a_unused_high: assert property ( // R10
    async_mode_in == LCR_AS_CLR |-> async_pre_n)
    else $error("unused preset not held high");

  a_unused_clear: assert property ( // R10
    async_mode_in == LCR_AS_PRE |-> async_clr_n)
    else $error("unused clear not held high");

  a_counter_nocasc: assert property ( // R1
    op_mode_in == LCR_OP_UPDN || op_mode_in == LCR_OP_CLRCNT |-> !cascade_out)
    else $error("counter mode drove cascade out");

  a_bus_level: assert property ( // R7
    tbus_en_in == 4'h0 |=> tbus_out)
    else $error("idle bus not high one cycle later");

endmodule
`default_nettype wire

// ==== tb/lcr_nbr_model.sv ====
// Preceding neighbour cell feeding the carry and cascade chains
`timescale 1ns/100ps
`default_nettype none
module lcr_nbr_model (
  // Reset
  input  wire logic nrst_in,
  // Values the neighbour should present
  input  wire logic carry_req_in,
  input  wire logic cascade_req_in,
  // Chain outputs toward the cell
  output logic      carry_chain_out,
  output logic      cascade_chain_out
);
  // Chains sit low while the neighbour is held in reset
  assign carry_chain_out   = nrst_in & carry_req_in;
  assign cascade_chain_out = nrst_in & cascade_req_in;
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the logic cell
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lcr_pkg::*;
  typedef struct packed {logic [1:0] sel; logic val;} lcr_note_t;
  logic            sys_clk_in, nrst_in, clr_sel, en_sel, d1, d2, d3, d4;
  logic            cin_req, casc_req, ca, cb, carry_c, casc_c, q;
  logic            reg_o, carry_o, casc_o, tbus_o;
  lcr_op_mode_t    op;
  lcr_async_mode_t am;
  logic [15:0]     mask;
  logic [3:0]      tdat, ten;
  lcr_note_t       notes [$];
  int              n_mismatch = 0;
  int              checks_done = 0;
  logic [31:0]     seed = 32'hb6eb;
  string           sig_name [4] = '{"reg_out", "carry_out", "cascade_out", "tbus_out"};
  // Async table: mode, clear select, line a, line b, third input, expected
  logic [7:0]      async_tab [12] = '{8'h29, 8'h14, 8'h35, 8'h08, 8'h45, 8'h4c,
                                      8'hab, 8'ha8, 8'h85, 8'h6e, 8'h6b, 8'he1};

  // Clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  lcr_nbr_model nbr (
    .nrst_in          (nrst_in),
    .carry_req_in     (cin_req),
    .cascade_req_in   (casc_req),
    .carry_chain_out  (carry_c),
    .cascade_chain_out(casc_c)
  );

  lcr_cell DUT (
    .sys_clk_in          (sys_clk_in),
    .nrst_in             (nrst_in),
    .op_mode_in          (op),
    .async_mode_in       (am),
    .clr_src_sel_in      (clr_sel),
    .en_sel_in           (en_sel),
    .lut_mask_in         (mask),
    .cell_input_first_in (d1),
    .cell_input_second_in(d2),
    .cell_input_third_in (d3),
    .cell_input_fourth_in(d4),
    .carry_chain_in      (carry_c),
    .cascade_chain_in    (casc_c),
    .cluster_ctrl_a_in   (ca),
    .cluster_ctrl_b_in   (cb),
    .tbus_data_in        (tdat),
    .tbus_en_in          (ten),
    .reg_out             (reg_o),
    .carry_out           (carry_o),
    .cascade_out         (casc_o),
    .tbus_out            (tbus_o)
  );

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic note(input logic [1:0] s, input logic v);
    notes.push_back(lcr_note_t'{s, v});
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Random bus sources, then on to the next falling edge
  task automatic step();
    logic [31:0] r;
    r = rnd();
    {tdat, ten} = r[7:0];
    note(2'h3, (ten == 4'h0) ? 1'b1 : ($countones(ten) > 1) ? 1'b0 : |(tdat & ten));
    @(negedge sys_clk_in);
  endtask

  // Expected register, carry and cascade for the present inputs
  task automatic run_cycle();
    logic nx;
    logic cy;
    logic cs;
    // Neighbour passes its requests straight through once out of reset
    case (op)
      LCR_OP_NORMAL: nx = mask[{d4, d3, d2, d1}] & casc_req;
      LCR_OP_ARITH:  nx = mask[{1'b0, cin_req, d2, d1}] & casc_req;
      LCR_OP_UPDN:   nx = d4 ? d3 : q ^ cin_req;
      default:       nx = (d4 ? d3 : mask[{1'b0, cin_req, d2, q}]) & ~casc_req;
    endcase
    cs = (op == LCR_OP_NORMAL || op == LCR_OP_ARITH) ? nx : 1'b0;
    if (!(en_sel && !d1))
      q = nx;
    case (op)
      LCR_OP_NORMAL: cy = 1'b0;
      LCR_OP_ARITH:  cy = mask[{1'b1, cin_req, d2, d1}];
      LCR_OP_UPDN:   cy = (casc_req ? q : ~q) & cin_req;
      default:       cy = mask[{1'b1, cin_req, d2, q}];
    endcase
    note(2'h0, q);
    note(2'h1, cy);
    note(2'h2, cs);
    step();
  endtask

  // Monitor: compare oldest notes once the edge has settled
  initial
  begin
    logic      seen;
    lcr_note_t n;
    forever
    begin
      @(posedge sys_clk_in);
      #1;
      while (notes.size() > 0)
      begin
        n = notes.pop_front();
        seen = (n.sel == 2'h0) ? reg_o : (n.sel == 2'h1) ? carry_o :
               (n.sel == 2'h2) ? casc_o : tbus_o;
        checks_done++;
        if (seen !== n.val)
        begin
          n_mismatch++;
          $display("ERROR %s expected %b seen %b", sig_name[n.sel], n.val, seen);
        end
      end
    end
  end

  // Watchdog
  initial
  begin
    repeat (1000) @(posedge sys_clk_in);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    logic [31:0] r;
    logic [7:0]  e;
    nrst_in = 1'b0;
    op = LCR_OP_NORMAL;
    am = lcr_async_mode_t'(3'h7);
    mask = 16'h0000;
    q = 1'b0;
    {clr_sel, en_sel, d1, d2, d3, d4, cin_req, casc_req, ca, cb, tdat, ten} = '0;
    repeat (5) @(negedge sys_clk_in);
    note(2'h0, 1'b0);
    note(2'h3, 1'b1);
    @(negedge sys_clk_in);
    nrst_in = 1'b1;
    // Every operating mode with random inputs, no async control
    for (int m = 0; m < 4; m++)
    begin
      op = lcr_op_mode_t'(m);
      r = rnd();
      mask = r[15:0];
      for (int i = 0; i < 16; i++)
      begin
        r = rnd();
        {d4, d3, d2, d1, cin_req, casc_req, en_sel, ca, cb, clr_sel} = r[9:0];
        run_cycle();
      end
    end
    // Async modes with the enable held off
    op = LCR_OP_NORMAL;
    {en_sel, d1} = 2'b10;
    for (int i = 0; i < 12; i++)
    begin
      e = async_tab[i];
      am = lcr_async_mode_t'(e[7:5]);
      {clr_sel, ca, cb, d3} = e[4:1];
      q = e[0];
      note(2'h0, q);
      step();
    end
    // Reset again in mid-run
    nrst_in = 1'b0;
    note(2'h0, 1'b0);
    note(2'h3, 1'b1);
    @(negedge sys_clk_in);
    nrst_in = 1'b1;
    note(2'h0, 1'b0);
    step();
    end_of_test();
  end
endmodule
`default_nettype wire
